// *** hdl/bfb_pkg.sv ***
// Purpose: Shared constants and types for the burst flash bus bridge.
// Assumes: One 250 MHz clock (4 ns), synchronous active-high reset.
// Notes: Cycle numbers count from the cycle after the address strobe is seen.
package bfb_pkg;
	// Default burst counter width; four beats per burst
	localparam int CNT_W_DEF = 2;
	// Register bus geometry
	localparam int AXI_AW = 4;
	localparam int AXI_DW = 32;
	localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
	localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
	// Control fields
	localparam int CTRL_OPT_BIT = 0;
	localparam int CTRL_NOLAST_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// Status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_MODE_BIT = 1;
	localparam int STAT_CNT_LSB = 8;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Read schedule, in cycles after the strobe
	localparam int N_SEL = 1;
	localparam int N_FIRST_RD = 2;
	localparam int N_OE = 4;
	localparam int N_INIT_INC = 3;
	localparam int N_INIT_RDY = 7;
	localparam int N_INIT_TAIL = 4;
	localparam int N_OPT_INC = 2;
	localparam int N_OPT_RDY = 5;
	// Controller states
	typedef enum logic [2:0]
	{
		BFB_IDLE,
		BFB_SEL,
		BFB_RD,
		BFB_WSEL,
		BFB_WPULSE,
		BFB_WDONE
	} bfb_state_t;
endpackage : bfb_pkg

// *** hdl/bfb_flash_bridge.sv ***
// Purpose: Burst bus to synchronous flash bridge with an AXI4-Lite control port.
// Assumes: Processor and flash pins arrive asynchronously and are resynchronised.
// Notes: Control register picks slow or fast read timing; status shows activity.
`timescale 1ns/1ps

// Notes on behaviour
// - Counter loads low address bits at start.
// - Address-valid strobe asserted right after read start.
// - Flash not selected: abandon, back to idle.
// - Slow mode: strobe gaps on even cycles.
// - Slow mode: counter advances at 3, 5, 7.
// - Output enable asserted from cycle four.
// - Slow mode: first data valid cycle seven.
// - Slow mode: ready at 7, 9, 11, 12.
// - Last-beat sampled: end read, go idle.
// - Fast mode: strobe held, counter at 2-4.
// - Fast mode: ready at 5, 6, 7, 8.
// - Writes hold captured address throughout.
// - No last-beat: length from low address.
// - Counter width parameter allows eight beats.
// - After reset, slow read timing is used.
// - Reset: state idle, counts zero, pins and syncs high.
module bfb_flash_bridge
#(
	parameter int CNT_W = bfb_pkg::CNT_W_DEF
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Processor burst bus
	input wire logic addr_strobe_n,
	input wire logic write_not_read,
	input wire logic last_beat_n,
	input wire logic [CNT_W-1:0] low_burst_addr_bits,
	output logic ready_return_n,
	// Flash side
	input wire logic flash_select_n,
	output logic addr_valid_strobe_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [CNT_W-1:0] burst_count,
	// AXI4-Lite slave
	input wire logic [bfb_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [bfb_pkg::AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bfb_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [bfb_pkg::AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import bfb_pkg::*;

	localparam int BEATS = 1 << CNT_W;
	localparam int CYC_W = $clog2(2 * BEATS + N_INIT_TAIL + 2);
	localparam int SW = CNT_W + 4;
	localparam logic [CYC_W-1:0] C_SEL = CYC_W'(N_SEL);
	localparam logic [CYC_W-1:0] C_FIRST = CYC_W'(N_FIRST_RD);
	localparam logic [CYC_W-1:0] C_OE = CYC_W'(N_OE);
	localparam logic [CYC_W-1:0] C_IINC = CYC_W'(N_INIT_INC);
	localparam logic [CYC_W-1:0] C_IINC_END = CYC_W'(2 * BEATS - 1);
	localparam logic [CYC_W-1:0] C_IRDY = CYC_W'(N_INIT_RDY);
	localparam logic [CYC_W-1:0] C_IRDY_LAST = CYC_W'(2 * BEATS + N_INIT_TAIL);
	localparam logic [CYC_W-1:0] C_OINC = CYC_W'(N_OPT_INC);
	localparam logic [CYC_W-1:0] C_OINC_END = CYC_W'(BEATS);
	localparam logic [CYC_W-1:0] C_ORDY = CYC_W'(N_OPT_RDY);
	localparam logic [CYC_W-1:0] C_ORDY_END = CYC_W'(BEATS + N_OPT_RDY - 1);
	localparam logic [CNT_W:0] BEATS_V = (CNT_W+1)'(BEATS);

	bfb_state_t state_q, state_d;
	logic [SW-1:0] meta_q, sync_q;
	logic strobe_prev_q;
	logic [CYC_W-1:0] cyc_q, cyc_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic [CNT_W:0] beat_q, total_q;
	logic mode_q, nolast_q;
	logic adv_n_q, oe_n_q, we_n_q, rdy_n_q;
	logic [1:0] ctrl_q;
	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [AXI_AW-1:0] aw_addr_q;
	logic [AXI_DW-1:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	// Resynchronised pins; only the second stage is read by logic
	wire strobe_n_s = sync_q[0];
	wire wnr_s = sync_q[1];
	wire last_n_s = sync_q[2];
	wire sel_n_s = sync_q[3];
	wire [CNT_W-1:0] addr_s = sync_q[SW-1:4];

	// Start decode on the strobe's falling edge, since the slow bus holds it many cycles
	wire idle = (state_q == BFB_IDLE);
	wire strobe_fall = strobe_prev_q & ~strobe_n_s;
	wire rd_start = idle & strobe_fall & ~wnr_s;
	wire wr_start = idle & strobe_fall & wnr_s;
	wire load = rd_start | wr_start;
	wire opt_d = rd_start ? ctrl_q[CTRL_OPT_BIT] : mode_q;
	wire nolast_d = load ? ctrl_q[CTRL_NOLAST_BIT] : nolast_q;
	wire last_seen = ~last_n_s & ~nolast_q;
	wire final_beat = (beat_q == total_q - (CNT_W+1)'(1));
	wire rd_end = (state_q == BFB_RD) & ~rdy_n_q & (last_seen | final_beat);
	wire wr_end = ~last_n_s | nolast_q;

	// Next state of the read and write sequencer
	always_comb
	begin
		state_d = state_q;
		cyc_d = cyc_q + CYC_W'(1);
		case (state_q)
			BFB_IDLE:
			begin
				cyc_d = '0;
				if (rd_start)
				begin
					state_d = BFB_SEL;
					cyc_d = C_SEL;
				end
				else if (wr_start)
					state_d = BFB_WSEL;
			end
			BFB_SEL:
				state_d = sel_n_s ? BFB_IDLE : BFB_RD;
			BFB_RD:
				if (rd_end)
					state_d = BFB_IDLE;
			BFB_WSEL:
				state_d = sel_n_s ? BFB_IDLE : BFB_WPULSE;
			BFB_WPULSE:
				state_d = BFB_WDONE;
			BFB_WDONE:
				state_d = wr_end ? BFB_IDLE : BFB_WPULSE;
			default:
				state_d = BFB_IDLE;
		endcase
	end

	// Pin levels for the coming cycle, so every pin leaves a flop
	wire rd_nx = (state_d == BFB_RD);
	wire odd_nx = cyc_d[0];
	wire init_acc = rd_nx & odd_nx & (cyc_d >= C_IINC) & (cyc_d <= C_IINC_END);
	wire opt_inc = rd_nx & (cyc_d >= C_OINC) & (cyc_d <= C_OINC_END);
	wire adv_act = (state_d == BFB_SEL) | (opt_d ? rd_nx : init_acc);
	wire inc = opt_d ? opt_inc : init_acc;
	wire oe_act = rd_nx & (cyc_d >= C_OE);
	wire init_rdy = (cyc_d == C_IRDY_LAST) | (odd_nx & (cyc_d >= C_IRDY) & (cyc_d < C_IRDY_LAST));
	wire opt_rdy = (cyc_d >= C_ORDY) & (cyc_d <= C_ORDY_END);
	wire rdy_act = (state_d == BFB_WDONE) | (rd_nx & (opt_d ? opt_rdy : init_rdy));
	wire we_act = (state_d == BFB_WPULSE);

	// Counter loads, wraps by its width, and otherwise holds; writes never step it
	assign count_d = load ? addr_s : (inc ? count_q + CNT_W'(1) : count_q);

	// Pin synchronisers
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			meta_q <= '1;
			sync_q <= '1;
			strobe_prev_q <= 1'b1;
		end
		else
		begin
			meta_q <= {low_burst_addr_bits, flash_select_n, last_beat_n, write_not_read,
				addr_strobe_n};
			sync_q <= meta_q;
			strobe_prev_q <= strobe_n_s;
		end
	end

	// Sequencer, counter and flash strobes
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_q <= BFB_IDLE;
			cyc_q <= '0;
			count_q <= '0;
			mode_q <= 1'b0;
			nolast_q <= 1'b0;
			adv_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			rdy_n_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			cyc_q <= cyc_d;
			count_q <= count_d;
			mode_q <= opt_d;
			nolast_q <= nolast_d;
			adv_n_q <= ~adv_act;
			oe_n_q <= ~oe_act;
			we_n_q <= ~we_act;
			rdy_n_q <= ~rdy_act;
		end
	end

	// Beat tally; without a last-beat pin the burst runs to the wrap point
	always_ff @(posedge sys_clk)
	begin
		if (reset | idle)
		begin
			beat_q <= '0;
			// Start address trims the burst only when the last-beat pin is ignored
			total_q <= (load & ctrl_q[CTRL_NOLAST_BIT]) ? BEATS_V - {1'b0, addr_s} : BEATS_V;
		end
		else if ((state_q == BFB_RD) & ~rdy_n_q)
			beat_q <= beat_q + (CNT_W+1)'(1);
	end

	assign addr_valid_strobe_n = adv_n_q;
	assign flash_oe_n = oe_n_q;
	assign flash_we_n = we_n_q;
	assign ready_return_n = rdy_n_q;
	assign burst_count = count_q;

	// Register bus decode; unmapped addresses answer with a slave error
	wire [AXI_AW-1:0] aw_word = {aw_addr_q[AXI_AW-1:2], 2'h0};
	wire [AXI_AW-1:0] ar_word = {s_axi_araddr[AXI_AW-1:2], 2'h0};
	wire do_write = aw_have_q & w_have_q & ~bvalid_q;
	wire wr_mapped = (aw_word == REG_CTRL) | (aw_word == REG_STATUS);
	wire ar_take = arready_q & s_axi_arvalid;
	logic [AXI_DW-1:0] status_word;
	always_comb
	begin
		status_word = '0;
		status_word[STAT_BUSY_BIT] = ~idle;
		status_word[STAT_MODE_BIT] = mode_q;
		status_word[STAT_CNT_LSB +: CNT_W] = count_q;
	end
	wire rd_mapped = (ar_word == REG_CTRL) | (ar_word == REG_STATUS);
	wire [AXI_DW-1:0] rd_word = (ar_word == REG_CTRL) ? {30'h0, ctrl_q} :
		(ar_word == REG_STATUS) ? status_word : 32'h0;

	// Write channels are taken in either order, answered once both are held
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			ctrl_q <= CTRL_RST;
		end
		else
		begin
			if (awready_q & s_axi_awvalid)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (wready_q & s_axi_wvalid)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			awready_q <= ~(awready_q & s_axi_awvalid) & ~aw_have_q & ~bvalid_q;
			wready_q <= ~(wready_q & s_axi_wvalid) & ~w_have_q & ~bvalid_q;
			if (do_write)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
				if ((aw_word == REG_CTRL) & wstrb_q[0])
					ctrl_q <= wdata_q[1:0];
			end
			else if (bvalid_q & s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Read channel, one outstanding read
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end
		else
		begin
			arready_q <= ~ar_take & ~rvalid_q;
			if (ar_take)
			begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_q & s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Checks on the flash sequencing
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire in_rd = (state_q == BFB_RD);
	sequence s_opt_beats;
		!rdy_n_q [*4];
	endsequence
	a_count_load: assert property (load |=> count_q == $past(addr_s))
		else $error("counter did not load low address");
	a_adv_first: assert property (rd_start |=> !adv_n_q && state_q == BFB_SEL)
		else $error("address valid not asserted at start");
	a_abort_idle: assert property (state_q == BFB_SEL && sel_n_s |=> idle && adv_n_q)
		else $error("unselected access not abandoned");
	a_init_gap: assert property (in_rd && !mode_q && cyc_q == C_IINC - CYC_W'(1) |-> adv_n_q ##1 !adv_n_q)
		else $error("slow mode address valid gap wrong");
	a_init_step: assert property (in_rd && !mode_q && cyc_q == C_IINC |-> count_q == $past(count_q) + CNT_W'(1))
		else $error("slow mode counter did not step");
	a_oe_on: assert property (in_rd && cyc_q >= C_OE |-> !oe_n_q)
		else $error("output enable missing");
	a_oe_early: assert property (in_rd && cyc_q < C_OE |-> oe_n_q)
		else $error("output enable too early");
	a_init_ready: assert property (in_rd && !mode_q && cyc_q == C_IRDY - CYC_W'(1) |-> rdy_n_q ##1 !rdy_n_q)
		else $error("slow mode first ready not at cycle seven");
	a_init_tail: assert property (in_rd && !mode_q && !rdy_n_q && cyc_q == C_IRDY_LAST - CYC_W'(1) |-> ##1 !rdy_n_q || idle)
		else $error("slow mode final ready not back to back");
	a_opt_adv: assert property (in_rd && mode_q |-> !adv_n_q)
		else $error("fast mode address valid dropped");
	a_opt_beats: assert property (state_q == BFB_SEL && mode_q && !sel_n_s && last_n_s && total_q == BEATS_V |-> ##(N_OPT_RDY - 1) s_opt_beats)
		else $error("fast mode ready beats wrong");
	a_last_end: assert property (in_rd && !rdy_n_q && last_seen |=> idle)
		else $error("read did not end on last beat");
	a_write_hold: assert property ((state_q == BFB_WPULSE || state_q == BFB_WDONE) |-> $stable(count_q))
		else $error("write address changed");
	a_write_pulse: assert property (state_q == BFB_WPULSE |-> !flash_we_n ##1 flash_we_n && !rdy_n_q)
		else $error("write enable pulse wrong");
	a_count_wrap: assert property (!load && inc && count_q == '1 |=> count_q == '0)
		else $error("counter did not wrap");
endmodule : bfb_flash_bridge

// *** tb/bfb_proc_model.sv ***
// Purpose: Processor and flash-select side of the burst bus.
// Assumes: Pins change just after a rising edge, by NBA.
// Notes: Released address lines show the inverse of the last value.
`timescale 1ns/1ps
module bfb_proc_model
(
	// Clock
	input wire logic sys_clk,
	// Pins toward the bridge
	output logic addr_strobe_n,
	output logic write_not_read,
	output logic last_beat_n,
	output logic [1:0] low_burst_addr_bits,
	output logic flash_select_n
);
	// Idle bus at time zero
	initial
	begin
		addr_strobe_n = 1'b1;
		write_not_read = 1'b0;
		last_beat_n = 1'b1;
		low_burst_addr_bits = 2'h0;
		flash_select_n = 1'b1;
	end

	// Strobe held four cycles, the slow side clock outlasts the sync
	task automatic start(input logic w, input logic [1:0] a, input logic s, input logic l);
		@(posedge sys_clk);
		addr_strobe_n <= 1'b0;
		write_not_read <= w;
		low_burst_addr_bits <= a;
		flash_select_n <= s;
		last_beat_n <= l;
		repeat (4) @(posedge sys_clk);
		addr_strobe_n <= 1'b1;
		write_not_read <= ~w;
		low_burst_addr_bits <= ~a;
	endtask : start

	// Release select and last, then leave the bus quiet
	task automatic finish;
		last_beat_n <= 1'b1;
		flash_select_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : finish
endmodule : bfb_proc_model

// *** tb/tb_burst_flash_bus_interface.sv ***
// Purpose: Self-checking bench for the burst flash bridge.
// Assumes: Partner model drives processor pins; bench speaks AXI4-Lite.
// Notes: Read beat times are measured from the first address-valid strobe; the write beat from the write-enable pulse.
`timescale 1ns/1ps
module tb_burst_flash_bus_interface;
	import bfb_pkg::*;
	// Stimulus and observed signals
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic as_n, wnr, last_n, sel_n, rdy_n, adv_n, oe_n, we_n;
	logic [1:0] lba, cnt, br, rr, c1, cw;
	logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hF;
	logic [31:0] wd = 32'h0, rd;
	logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic awr, wr, bv, arr, rv;
	logic [6:0] am;
	int failures = 0, samples_checked = 0, cyc = 0, t0 = -1, oe0 = -1;
	int rq[$], wq[$];

	// 4 ns clock
	always #2 sys_clk = ~sys_clk;

	bfb_flash_bridge bfb_flash_bridge_inst
	(
		.sys_clk(sys_clk), .reset(reset), .addr_strobe_n(as_n),
		.write_not_read(wnr), .last_beat_n(last_n), .low_burst_addr_bits(lba),
		.ready_return_n(rdy_n), .flash_select_n(sel_n), .addr_valid_strobe_n(adv_n),
		.flash_oe_n(oe_n), .flash_we_n(we_n), .burst_count(cnt),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd)
	);

	bfb_proc_model bfb_proc_model_inst
	(
		.sys_clk(sys_clk), .addr_strobe_n(as_n), .write_not_read(wnr),
		.last_beat_n(last_n), .low_burst_addr_bits(lba), .flash_select_n(sel_n)
	);

	task automatic complete_run;
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	// Monitor: pre-edge values, timeout cuts a hang short
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			complete_run();
		end
		if (adv_n === 1'b0 && t0 < 0)
			t0 = cyc;
		if (adv_n === 1'b0 && t0 >= 0 && cyc - t0 < 7)
			am[cyc - t0] = 1'b1;
		if (rdy_n === 1'b0)
		begin
			if (rq.size() == 0)
				c1 = cnt;
			rq.push_back(cyc);
		end
		if (oe_n === 1'b0 && oe0 < 0)
			oe0 = cyc;
		if (we_n === 1'b0)
		begin
			wq.push_back(cyc);
			cw = cnt;
		end
	end

	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge sys_clk);
			if (awv && awr === 1'b1)
				awv <= 1'b0;
			if (wv && wr === 1'b1)
				wv <= 1'b0;
			if (bv === 1'b1)
			begin
				r = br;
				brd <= 1'b0;
				break;
			end
		end
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge sys_clk);
			if (arv && arr === 1'b1)
				arv <= 1'b0;
			if (rv === 1'b1)
			begin
				d = rd;
				r = rr;
				rrd <= 1'b0;
				break;
			end
		end
	endtask : axr

	// One access; the offset array holds the documented beat offsets
	task automatic burst(input logic w, input int f, input logic [1:0] a, input logic s,
		input logic l, input int nb);
		int off[4];
		if (f)
			off = '{4, 5, 6, 7};
		else
			off = '{6, 8, 10, 11};
		rq = {};
		wq = {};
		t0 = -1;
		oe0 = -1;
		am = 7'h0;
		bfb_proc_model_inst.start(w, a, s, l);
		for (int i = 0; i < 40 && rq.size() < nb; i++)
			@(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
		bfb_proc_model_inst.finish();
		check(rq.size(), nb);
		if (w)
		begin
			check(wq.size(), 1);
			check(rq[0] - wq[0], 1);
			check(cw, a);
		end
		else if (!s)
		begin
			for (int i = 0; i < nb; i++)
				check(rq[i] - t0, off[i]);
			check(oe0 - t0, 3);
			check(c1, 2'(a + 2'd3));
			if (nb == 4)
				check(am, f ? 7'h7F : 7'h55);
		end
		else
			check(oe0, -1);
	endtask : burst

	// Main sequence
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(32'h188C7892));
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (6) @(posedge sys_clk);
		axr(REG_CTRL, d, r);
		check(d, 32'h0);
		burst(1'b0, 0, 2'($urandom), 1'b0, 1'b1, 4);
		burst(1'b0, 0, 2'($urandom), 1'b0, 1'b0, 1);
		burst(1'b0, 0, 2'h1, 1'b1, 1'b1, 0);
		burst(1'b1, 0, 2'($urandom), 1'b0, 1'b0, 1);
		axr(4'h8, d, r);
		check(r, RESP_SLVERR);
		check(d, 32'h0);
		axw(REG_STATUS, 32'hFF, r);
		check(r, RESP_OKAY);
		// Flash latency assumed programmed to 2 before fast timing
		axw(REG_CTRL, 32'h1, r);
		axr(REG_CTRL, d, r);
		check(d, 32'h1);
		burst(1'b0, 1, 2'($urandom), 1'b0, 1'b1, 4);
		burst(1'b0, 1, 2'($urandom), 1'b0, 1'b0, 1);
		axw(REG_CTRL, 32'h2, r);
		burst(1'b0, 0, 2'h2, 1'b0, 1'b1, 2);
		complete_run();
	end
endmodule : tb_burst_flash_bus_interface
